/* rtl/cbsc_ctrl.sv */
// three stage character buffer control with memory store and load
// assumes phase pulses and bit ticks are one-cycle strobes from the
// character timer, and the cursor level comes from the refresh memory
`timescale 1ns/100ps
module cbsc_ctrl #(
  parameter int CURSOR_WAIT_CYCLES = cbsc_pkg::CURSOR_WAIT_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [3:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // character timing
  input wire logic phase_one,
  input wire logic phase_three,
  input wire logic phase_four,
  input wire logic parity_pulse,
  input wire logic bit_tick,
  // serial receiver
  input wire logic [6:0] rx_char,
  input wire logic rx_char_done,
  // serial transmitter
  output logic [6:0] tx_char,
  output logic tx_char_valid,
  // refresh memory
  input wire logic cursor_at_entry,
  input wire logic mem_bit_in,
  output logic mem_bit_out,
  output logic mem_write_strobe,
  output logic cursor_step_request,
  output logic memory_shift_gate,
  output logic entry_write_gate,
  // pair gates
  output logic first_pair_shift_gate,
  output logic second_pair_shift_gate,
  // edit functions
  output logic function_start,
  output logic [6:0] function_code,
  input wire logic function_done
);
  cbsc_pkg::cbsc_state_e state;
  logic [1:0] ctrl;
  logic stage_one_full;
  logic stage_two_full;
  logic stage_three_full;
  logic esc_flag;
  logic control_pending_flag;
  logic checked;
  logic cursor_seen;
  logic cursor_late;
  logic [2:0] bit_cnt;
  logic [cbsc_pkg::WAIT_W-1:0] wait_cnt;
  logic receive_active;
  logic transmit_active;
  logic rx;
  logic tx;
  logic rx_path_en;
  logic want;
  logic store_ok;
  logic fire;
  logic sdl_start_rx;
  logic about_to_store;
  logic move12;
  logic move23;
  logic dec_now;
  logic end_clear;
  logic shifting;
  logic shift_done;
  logic d_discard;
  logic d_esc;
  logic d_etx;
  logic d_lf;
  logic d_ctrl;
  logic [3:0] ld;
  logic [3:0] sh;
  logic [3:0] shin;
  logic [6:0] ldd [4];
  logic [6:0] q [4];

  assign receive_active = ctrl[cbsc_pkg::CTRL_RX_BIT];
  assign transmit_active = ctrl[cbsc_pkg::CTRL_TX_BIT];
  assign rx = receive_active && !transmit_active;
  assign tx = transmit_active && !receive_active;
  assign rx_path_en = rx && !control_pending_flag;

  // stages: 0 one, 1 two, 2 three, 3 entry register
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_stage
      cbsc_stage u_stage (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .load(ld[gi]),
        .load_data(ldd[gi]),
        .shift(sh[gi]),
        .shift_in(shin[gi]),
        .q(q[gi])
      );
    end
  endgenerate

  cbsc_decode u_decode (
    .code(q[2]),
    .esc_seen(esc_flag),
    .is_discard(d_discard),
    .is_esc(d_esc),
    .is_etx(d_etx),
    .is_lf(d_lf),
    .is_ctrl(d_ctrl)
  );

  // decode once per character, on phase four, before it is stored
  assign dec_now = ce && phase_four && rx && stage_three_full && !checked && !memory_shift_gate;
  assign end_clear = (dec_now && d_etx) || (tx && parity_pulse && stage_three_full && d_etx);
  assign store_ok = checked || !(d_etx || d_discard || d_esc || d_ctrl);
  assign want = rx ? (rx_path_en && stage_three_full && store_ok) : (tx && !stage_one_full);
  assign fire = phase_four && cursor_seen && want && state == cbsc_pkg::CBSC_SEEK;
  assign sdl_start_rx = ce && fire && rx;
  assign about_to_store = sdl_start_rx;

  // gates: first pair never reaches stage three or memory
  assign first_pair_shift_gate = stage_one_full && (!stage_two_full || !stage_three_full
    || about_to_store);
  assign second_pair_shift_gate = stage_two_full && (!stage_three_full || about_to_store);
  assign move12 = ce && first_pair_shift_gate;
  assign move23 = ce && second_pair_shift_gate;

  assign shifting = state == cbsc_pkg::CBSC_SHIFT;
  assign shift_done = ce && shifting && bit_tick && bit_cnt == cbsc_pkg::SHIFT_LAST;
  assign memory_shift_gate = state == cbsc_pkg::CBSC_ARMED || state == cbsc_pkg::CBSC_WRWAIT || shifting;

  // stage wiring: loads and shifts are exclusive per stage
  always_comb begin
    ld[0] = rx && rx_char_done;
    ldd[0] = rx_char;
    sh[0] = tx && shifting && bit_tick;
    shin[0] = mem_bit_in;
    ld[1] = first_pair_shift_gate;
    ldd[1] = q[0];
    sh[1] = 1'b0;
    shin[1] = 1'b0;
    ld[2] = second_pair_shift_gate;
    ldd[2] = q[1];
    sh[2] = 1'b0;
    shin[2] = 1'b0;
    ld[3] = fire && rx;
    ldd[3] = q[2];
    sh[3] = rx && shifting && bit_tick;
    shin[3] = 1'b0;
  end

  // store and load sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= cbsc_pkg::CBSC_IDLE;
    end else if (ce) begin
      case (state)
        cbsc_pkg::CBSC_IDLE: begin
          if (rx || tx) begin
            state <= cbsc_pkg::CBSC_SEEK;
          end
        end
        cbsc_pkg::CBSC_SEEK: begin
          if (!(rx || tx)) begin
            state <= cbsc_pkg::CBSC_IDLE;
          end else if (fire) begin
            state <= cbsc_pkg::CBSC_ARMED;
          end
        end
        cbsc_pkg::CBSC_ARMED: begin
          if (phase_one) begin
            state <= rx ? cbsc_pkg::CBSC_WRWAIT : cbsc_pkg::CBSC_SHIFT;
          end
        end
        cbsc_pkg::CBSC_WRWAIT: begin
          if (phase_three) begin
            state <= cbsc_pkg::CBSC_SHIFT;
          end
        end
        cbsc_pkg::CBSC_SHIFT: begin
          // back to the search at once: the stepped cursor sits at entry again
          if (shift_done) begin
            state <= cbsc_pkg::CBSC_SEEK;
          end
        end
        default: begin
          state <= cbsc_pkg::CBSC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt <= '0;
    end else if (ce) begin
      if (!shifting) begin
        bit_cnt <= '0;
      end else if (bit_tick) begin
        bit_cnt <= bit_cnt + 3'h1;
      end
    end
  end

  // cursor seen only counts while a transfer is wanted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cursor_seen <= 1'b0;
    end else if (ce) begin
      if (state != cbsc_pkg::CBSC_SEEK || fire || !want) begin
        cursor_seen <= 1'b0;
      end else if (cursor_at_entry) begin
        cursor_seen <= 1'b1;
      end
    end
  end

  // late cursor: a revolution should never exceed the wait limit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt <= '0;
    end else if (ce) begin
      if (state != cbsc_pkg::CBSC_SEEK || !want || cursor_seen) begin
        wait_cnt <= '0;
      end else if (wait_cnt != CURSOR_WAIT_CYCLES[cbsc_pkg::WAIT_W-1:0]) begin
        wait_cnt <= wait_cnt + 20'h00001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cursor_late <= 1'b0;
    end else if (ce) begin
      if (wait_cnt == CURSOR_WAIT_CYCLES[cbsc_pkg::WAIT_W-1:0]) begin
        cursor_late <= 1'b1;
      end else if (psel && penable && pwrite && paddr == cbsc_pkg::STATUS_OFS && pwdata[cbsc_pkg::ST_LATE]) begin
        cursor_late <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      entry_write_gate <= 1'b0;
      cursor_step_request <= 1'b0;
    end else if (ce) begin
      cursor_step_request <= state == cbsc_pkg::CBSC_ARMED && phase_one;
      if (state == cbsc_pkg::CBSC_ARMED && phase_one && rx) begin
        entry_write_gate <= 1'b1;
      end else if (!memory_shift_gate || shift_done || !rx) begin
        entry_write_gate <= 1'b0;
      end
    end
  end

  assign mem_bit_out = q[3][0];
  assign mem_write_strobe = ce && rx && shifting && bit_tick && entry_write_gate;

  // full flags: a set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_one_full <= 1'b0;
    end else if (ce) begin
      if ((rx && rx_char_done) || (tx && shift_done)) begin
        stage_one_full <= 1'b1;
      end else if (move12 || end_clear) begin
        stage_one_full <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_two_full <= 1'b0;
    end else if (ce) begin
      if (move12) begin
        stage_two_full <= 1'b1;
      end else if (move23 || end_clear) begin
        stage_two_full <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_three_full <= 1'b0;
    end else if (ce) begin
      if (move23) begin
        stage_three_full <= 1'b1;
      end else if (sdl_start_rx) begin
        stage_three_full <= 1'b0;
      end else if (dec_now && (d_discard || d_esc || d_ctrl)) begin
        stage_three_full <= 1'b0;
      end else if (end_clear || (tx && parity_pulse)) begin
        stage_three_full <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      checked <= 1'b0;
    end else if (ce) begin
      if (move23) begin
        checked <= 1'b0;
      end else if (dec_now) begin
        checked <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      esc_flag <= 1'b0;
    end else if (ce) begin
      if (dec_now && d_esc) begin
        esc_flag <= 1'b1;
      end else if ((shift_done && rx) || end_clear || !rx) begin
        esc_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_pending_flag <= 1'b0;
    end else if (ce) begin
      if (dec_now && d_ctrl) begin
        control_pending_flag <= 1'b1;
      end else if (function_done || esc_flag) begin
        control_pending_flag <= 1'b0;
      end
    end
  end

  // line feed starts its function but leaves both flags alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      function_start <= 1'b0;
      function_code <= '0;
    end else if (ce) begin
      function_start <= dec_now && (d_ctrl || d_lf);
      if (dec_now && (d_ctrl || d_lf)) begin
        function_code <= q[2];
      end
    end
  end

  assign tx_char = q[2];
  assign tx_char_valid = tx && stage_three_full;

  // apb: zero wait states while ce is high, read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= cbsc_pkg::CTRL_RESET;
    end else if (ce && psel && penable && pwrite && paddr == cbsc_pkg::CTRL_OFS) begin
      ctrl <= pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (ce && psel && !penable) begin
      prdata <= '0;
      if (paddr == cbsc_pkg::CTRL_OFS) begin
        prdata <= {30'h00000000, ctrl};
      end else if (paddr == cbsc_pkg::STATUS_OFS) begin
        prdata <= {24'h000000, cursor_late, esc_flag, control_pending_flag, entry_write_gate,
          memory_shift_gate, stage_three_full, stage_two_full, stage_one_full};
      end
    end
  end

  assign pready = ce;
  assign pslverr = psel && penable && paddr != cbsc_pkg::CTRL_OFS && paddr != cbsc_pkg::STATUS_OFS;

  // checks
  logic [3:0] wr_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_cnt <= '0;
    end else if (ce) begin
      if (state == cbsc_pkg::CBSC_ARMED) begin
        wr_cnt <= '0;
      end else if (mem_write_strobe) begin
        wr_cnt <= wr_cnt + 4'h1;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  pair_one_move_a: assert property (
    move12 |=> stage_two_full && q[1] == $past(q[0]))
    else $error("first pair move lost");
  pair_two_move_a: assert property (
    move23 |=> stage_three_full && q[2] == $past(q[1]))
    else $error("second pair move lost");
  both_pairs_a: assert property (
    ce && stage_one_full && stage_two_full && !stage_three_full |=> q[2] == $past(q[1]) && q[1] == $past(q[0]))
    else $error("joint shift missing");
  gate_on_four_a: assert property (
    $rose(memory_shift_gate) |-> $past(phase_four) && $past(cursor_seen))
    else $error("memory gate set off phase four");
  step_pulse_a: assert property (
    cursor_step_request |-> $past(phase_one) && $past(state == cbsc_pkg::CBSC_ARMED))
    else $error("cursor step off phase one");
  seven_bits_a: assert property (
    shift_done && rx && entry_write_gate |=> wr_cnt == cbsc_pkg::SHIFT_TOTAL)
    else $error("store did not write seven bits");
  no_tx_write_a: assert property (
    tx |-> !mem_write_strobe && !entry_write_gate)
    else $error("memory written in transmit");
  pend_block_a: assert property (
    control_pending_flag && state == cbsc_pkg::CBSC_SEEK && rx |=> state != cbsc_pkg::CBSC_ARMED)
    else $error("store while function pending");
  esc_drop_a: assert property (
    dec_now && d_esc && !move23 |=> !stage_three_full && esc_flag && !memory_shift_gate)
    else $error("escape not dropped");
  idle_hold_a: assert property (
    ce && state == cbsc_pkg::CBSC_IDLE && !receive_active && !transmit_active |=> state == cbsc_pkg::CBSC_IDLE)
    else $error("left idle without activity");

  store_seen_c: cover property (shift_done && rx);
  escape_seen_c: cover property (dec_now && d_esc);
  load_seen_c: cover property (shift_done && tx);
  ctrl_seen_c: cover property (dec_now && d_ctrl ##[1:50] function_done);
endmodule // cbsc_ctrl

/* rtl/cbsc_decode.sv */
// classifies the character in stage three
// assumes the escape flag comes from the caller's flop
`timescale 1ns/100ps
module cbsc_decode (
  // input character
  input wire logic [cbsc_pkg::CHAR_W-1:0] code,
  input wire logic esc_seen,
  // classes
  output logic is_discard,
  output logic is_esc,
  output logic is_etx,
  output logic is_lf,
  output logic is_ctrl
);
  function automatic logic same(input logic [6:0] a, input logic [6:0] b);
    return a == b;
  endfunction
  logic live;
  // discards ignore the escape flag
  assign is_discard = same(code, cbsc_pkg::CODE_NUL) | same(code, cbsc_pkg::CODE_ENQ)
    | same(code, cbsc_pkg::CODE_BEL);
  assign live = !esc_seen && !is_discard;
  assign is_esc = live && same(code, cbsc_pkg::CODE_ESC);
  assign is_etx = live && same(code, cbsc_pkg::CODE_ETX);
  assign is_lf = live && same(code, cbsc_pkg::CODE_LF);
  assign is_ctrl = live && (code < cbsc_pkg::CTRL_LIMIT) && !same(code, cbsc_pkg::CODE_ESC)
    && !same(code, cbsc_pkg::CODE_ETX) && !same(code, cbsc_pkg::CODE_LF);
endmodule // cbsc_decode

/* rtl/cbsc_pkg.sv */
// package of constants shared by the buffer control files
// assumes a single clock domain at 40 MHz
package cbsc_pkg;
  localparam int CHAR_W = 7;
  localparam logic [2:0] SHIFT_LAST = 3'h6;
  localparam logic [3:0] SHIFT_TOTAL = 4'h7;
  localparam int CLK_HZ = 40000000;
  localparam int CURSOR_WAIT_MS = 16;
  localparam int CURSOR_WAIT_CYCLES = CURSOR_WAIT_MS * (CLK_HZ / 1000);
  localparam int WAIT_W = 20;
  // register map
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam int CTRL_RX_BIT = 0;
  localparam int CTRL_TX_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int ST_F1 = 0;
  localparam int ST_F2 = 1;
  localparam int ST_F3 = 2;
  localparam int ST_SDL = 3;
  localparam int ST_EWG = 4;
  localparam int ST_PEND = 5;
  localparam int ST_ESC = 6;
  localparam int ST_LATE = 7;
  // character codes
  localparam logic [6:0] CODE_NUL = 7'h00;
  localparam logic [6:0] CODE_ETX = 7'h03;
  localparam logic [6:0] CODE_ENQ = 7'h05;
  localparam logic [6:0] CODE_BEL = 7'h07;
  localparam logic [6:0] CODE_LF = 7'h0A;
  localparam logic [6:0] CODE_ESC = 7'h1B;
  localparam logic [6:0] CTRL_LIMIT = 7'h20;
  typedef enum logic [2:0] {CBSC_IDLE, CBSC_SEEK, CBSC_ARMED, CBSC_WRWAIT, CBSC_SHIFT} cbsc_state_e;
endpackage

/* rtl/cbsc_stage.sv */
// one seven bit buffer stage: parallel load or serial shift
// assumes load and shift are never asked in the same cycle
`timescale 1ns/100ps
module cbsc_stage (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // data
  input wire logic load,
  input wire logic [cbsc_pkg::CHAR_W-1:0] load_data,
  input wire logic shift,
  input wire logic shift_in,
  output logic [cbsc_pkg::CHAR_W-1:0] q
);
  // lsb leaves first, new bits enter at the top
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else if (ce) begin
      if (load) begin
        q <= load_data;
      end else if (shift) begin
        q <= {shift_in, q[cbsc_pkg::CHAR_W-1:1]};
      end
    end
  end
endmodule // cbsc_stage

/* verif/cbsc_far_model.sv */
// far side model: character timer and the recirculating refresh memory
// assumes one clock; stores are seen as seven strobed bits, lsb first
`timescale 1ns/100ps
module cbsc_far_model #(
  parameter logic [6:0] TX_CHAR = 7'h5D
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // character timer
  output logic phase_one,
  output logic phase_three,
  output logic phase_four,
  output logic parity_pulse,
  output logic bit_tick,
  // refresh memory
  input wire logic memory_shift_gate,
  input wire logic mem_write_strobe,
  input wire logic mem_bit_out,
  input wire logic cursor_step_request,
  output logic cursor_at_entry,
  output logic mem_bit_in,
  // observed stores
  output logic store_pulse,
  output logic [6:0] stored_char
);
  logic [5:0] t;
  logic [5:0] cur;
  logic [2:0] idx;
  logic [2:0] nbits;
  logic [6:0] sh;
  logic tog;
  // phases come 4, 1, 3 then seven bit ticks in one character time
  assign phase_four = (t == 6'h00);
  assign phase_one = (t == 6'h04);
  assign phase_three = (t == 6'h08);
  assign bit_tick = (t >= 6'h0A) && (t <= 6'h16) && !t[0];
  assign parity_pulse = (t == 6'h1E);
  // period 48 stays inside the shortened cursor wait of 50
  assign cursor_at_entry = (cur < 6'h06);
  // released line toggles so a stray sample never matches by luck
  assign mem_bit_in = (memory_shift_gate && idx != 3'h7) ? TX_CHAR[idx] : tog;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t <= 6'h00;
      cur <= 6'h00;
      tog <= 1'b0;
    end else begin
      t <= (t == 6'h27) ? 6'h00 : t + 6'h01;
      tog <= ~tog;
      // a step puts the next cell at the entry point at once
      cur <= (cursor_step_request || cur == 6'h2F) ? 6'h00 : cur + 6'h01;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx <= 3'h0;
      nbits <= 3'h0;
      sh <= 7'h00;
      store_pulse <= 1'b0;
      stored_char <= 7'h00;
    end else begin
      idx <= !memory_shift_gate ? 3'h0 : idx + 3'(bit_tick);
      store_pulse <= 1'b0;
      if (mem_write_strobe) begin
        sh <= {mem_bit_out, sh[6:1]};
        nbits <= (nbits == 3'h6) ? 3'h0 : nbits + 3'h1;
        if (nbits == 3'h6) begin
          store_pulse <= 1'b1;
          stored_char <= {mem_bit_out, sh[6:1]};
        end
      end
    end
  end
endmodule // cbsc_far_model

/* verif/char_buffer_shift_control_test.sv */
// self-checking bench for the three stage character buffer control
// assumes the far side model supplies character timing and memory
`timescale 1ns/100ps
module char_buffer_shift_control_test;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err;
  logic [3:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0] rx_char, tx_char, function_code, stored_char;
  logic rx_char_done, tx_char_valid, cursor_at_entry, mem_bit_in, mem_bit_out, mem_write_strobe;
  logic cursor_step_request, memory_shift_gate, entry_write_gate, first_pair_shift_gate;
  logic second_pair_shift_gate, function_start, store_pulse, function_done = 1'b0;
  logic phase_one, phase_three, phase_four, parity_pulse, bit_tick;
  int err_total, cmp_count, fn_seen, fn_wait, fn_exp, tx_writes, k, joint;
  bit esc, in_tx;
  logic [6:0] got_q[$];
  logic [6:0] exp_q[$];
  logic [6:0] fn_q[$];
  logic [6:0] ctl[5] = '{7'h08, 7'h0C, 7'h11, 7'h13, 7'h18};
  logic [6:0] disc[3] = '{cbsc_pkg::CODE_NUL, cbsc_pkg::CODE_ENQ, cbsc_pkg::CODE_BEL};

  cbsc_ctrl #(.CURSOR_WAIT_CYCLES(50)) dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .phase_one(phase_one),
    .phase_three(phase_three), .phase_four(phase_four), .parity_pulse(parity_pulse), .bit_tick(bit_tick),
    .rx_char(rx_char), .rx_char_done(rx_char_done), .tx_char(tx_char), .tx_char_valid(tx_char_valid),
    .cursor_at_entry(cursor_at_entry), .mem_bit_in(mem_bit_in), .mem_bit_out(mem_bit_out),
    .mem_write_strobe(mem_write_strobe), .cursor_step_request(cursor_step_request),
    .memory_shift_gate(memory_shift_gate), .entry_write_gate(entry_write_gate),
    .first_pair_shift_gate(first_pair_shift_gate), .second_pair_shift_gate(second_pair_shift_gate),
    .function_start(function_start), .function_code(function_code), .function_done(function_done)
  );
  cbsc_far_model far (
    .pclk(pclk), .presetn(presetn), .phase_one(phase_one), .phase_three(phase_three), .phase_four(phase_four),
    .parity_pulse(parity_pulse), .bit_tick(bit_tick), .memory_shift_gate(memory_shift_gate),
    .mem_write_strobe(mem_write_strobe), .mem_bit_out(mem_bit_out), .cursor_step_request(cursor_step_request),
    .cursor_at_entry(cursor_at_entry), .mem_bit_in(mem_bit_in), .store_pulse(store_pulse),
    .stored_char(stored_char)
  );

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  function automatic bit kept(input logic [6:0] c, input bit e);
    if (c == cbsc_pkg::CODE_NUL || c == cbsc_pkg::CODE_ENQ || c == cbsc_pkg::CODE_BEL) return 1'b0;
    return e || c >= cbsc_pkg::CTRL_LIMIT || c == cbsc_pkg::CODE_LF;
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a slave that never answers
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // host side: queue what memory should end up holding, then send
  task automatic host(input logic [6:0] c, input int gap);
    if (kept(c, esc)) exp_q.push_back(c);
    if (!esc && c < cbsc_pkg::CTRL_LIMIT && c != cbsc_pkg::CODE_ESC && kept(c, 1'b1)) begin
      fn_exp++;
      fn_q.push_back(c);
    end
    esc = !esc && c == cbsc_pkg::CODE_ESC;
    @(posedge pclk);
    rx_char <= c;
    rx_char_done <= 1'b1;
    @(posedge pclk);
    rx_char_done <= 1'b0;
    rx_char <= ~c;
    repeat (gap) @(posedge pclk);
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // edit functions finish a while after they start
  always @(posedge pclk) begin
    if (store_pulse === 1'b1) got_q.push_back(stored_char);
    if (in_tx && mem_write_strobe === 1'b1) tx_writes++;
    function_done <= (fn_wait == 1);
    if (function_start === 1'b1) begin
      chk("function code", {25'h0, fn_q.pop_front()}, {25'h0, function_code});
      fn_seen++;
      fn_wait = 20;
    end else if (fn_wait > 0) fn_wait--;
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, rx_char, rx_char_done, presetn} = '0;
    ce = 1'b1;
    void'($urandom(32'h1dbe2db7));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, cbsc_pkg::CTRL_OFS, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    apb(1'b0, cbsc_pkg::STATUS_OFS, 32'h0);
    chk("status reset", 32'h0, rd);
    ce <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("pready on hold", 32'h0, {31'h0, pready});
    ce <= 1'b1;
    apb(1'b1, 4'h8, 32'hFFFFFFFF);
    chk("unmapped error", 32'h1, {31'h0, err});
    apb(1'b1, cbsc_pkg::CTRL_OFS, 32'h1);
    apb(1'b0, cbsc_pkg::CTRL_OFS, 32'h0);
    chk("ctrl receive", 32'h1, rd);
    $display("test registers done");
    // a burst of three, 42 cycles apart: stages two and three fill before the first store starts
    repeat (3) host(7'h20 + 7'($urandom % 95), 40);
    repeat (300) @(posedge pclk);
    // discard in stage three with two behind it: both pairs move at once
    do @(posedge pclk); while (phase_four !== 1'b1);
    host(disc[$urandom % 3], 2);
    repeat (2) host(7'h20 + 7'($urandom % 95), 2);
    joint = 0;
    repeat (300) begin
      @(posedge pclk);
      if (first_pair_shift_gate === 1'b1 && second_pair_shift_gate === 1'b1) joint++;
    end
    chk("joint shift", 32'h1, joint);
    for (int i = 0; i < 24; i++) begin
      k = $urandom % 5;
      case (k)
        0: host(7'h20 + 7'($urandom % 95), 250);
        1: host(disc[$urandom % 3], 250);
        2: begin
          host(cbsc_pkg::CODE_ESC, 250);
          host(ctl[$urandom % 5], 250);
        end
        3: begin
          host(ctl[$urandom % 5], 250);
          host(cbsc_pkg::CODE_NUL, 250);
        end
        default: host(cbsc_pkg::CODE_LF, 250);
      endcase
    end
    repeat (400) @(posedge pclk);
    chk("store count", exp_q.size(), got_q.size());
    foreach (exp_q[i]) chk("stored char", {25'h0, exp_q[i]}, {25'h0, got_q[i]});
    chk("functions", fn_exp, fn_seen);
    $display("test receive done");
    host(cbsc_pkg::CODE_ETX, 300);
    apb(1'b0, cbsc_pkg::STATUS_OFS, 32'h0);
    chk("full flags", 32'h0, {24'h0, rd[7:0]});
    $display("test end of text done");
    apb(1'b1, cbsc_pkg::CTRL_OFS, 32'h2);
    in_tx = 1'b1;
    for (int n = 0; n < 3000 && tx_char_valid !== 1'b1; n++) @(posedge pclk);
    chk("tx char", 32'h5D, {25'h0, tx_char});
    repeat (400) @(posedge pclk);
    chk("tx writes", 32'h0, tx_writes);
    $display("test transmit done");
    give_verdict;
  end

  initial begin
    repeat (40000) @(posedge pclk);
    err_total++;
    $display("BAD watchdog expected finish seen hang");
    give_verdict;
  end
endmodule // char_buffer_shift_control_test
